// ==== gact_map.vh ====
`ifndef GACT_MAP_VH
`define GACT_MAP_VH
// byte addresses on the register port
`define GACT_ADDR_PIN_IO_CONTROL 8'h53
`define GACT_ADDR_POS_CURRENT 8'h60
`define GACT_ADDR_ACC_CLEAR 8'h62
`define GACT_ADDR_NEG_CURRENT 8'h64
`define GACT_ADDR_PACK_VOLTAGE 8'h68
`define GACT_ADDR_CELL_VOLTAGE 8'h6c
`define GACT_ADDR_SHELF_VOLTAGE 8'h70
// pin_io_control fields
`define GACT_BIT_PIN0_PUSH_PULL 7
`define GACT_BIT_PIN0_OUT_EN 6
`define GACT_BIT_PIN1_IN_EN 5
`define GACT_BIT_PIN0_IN_EN 4
`define GACT_BIT_PIN1_PULLDOWN 3
`define GACT_BIT_PIN0_OUT_VAL 2
`define GACT_BIT_PIN1_READBACK 1
`define GACT_BIT_PIN0_READBACK 0
// trip_control enable fields
`define GACT_BIT_CURRENT_EXIT 7
`define GACT_BIT_CURRENT_ENTRY 6
`define GACT_BIT_PACK_EXIT 5
`define GACT_BIT_CELL_ONE_ENTRY 4
`define GACT_BIT_CELL_TWO_ENTRY 3
`define GACT_BIT_SHELF_ENTRY 2
// result format
`define GACT_SIGN_BIT 15
`define GACT_MAG_MSB 14
// reset values
`define GACT_RESET_PIN_CTRL 6'h00
`define GACT_RESET_THRESHOLD 16'h0000
`define GACT_RESET_CLEAR 8'h00
`endif

// ==== gact_pin_model.sv ====
`timescale 1ns/1ps
module gact_pin_model (
	input wire therm_out,
	input wire therm_oe,
	input wire pulldown_en,
	input wire cell_drive,
	output wire therm_wire,
	output wire cell_wire
);
	// external pull-up holds a released line high
	assign therm_wire = therm_oe ? therm_out : 1'b1;
	assign cell_wire = pulldown_en ? 1'b0 : cell_drive;
endmodule // gact_pin_model

// ==== gact_regs.v ====
`timescale 1ns/1ps
`include "gact_map.vh"
// Contract
// - a set pin1 input enable makes the cell-two pin a readable digital input.
// - a clear pin1 input enable powers its buffer down and reads zero.
// - a one written to an accumulator-clear bit clears that accumulator, zero does nothing.
// - the accumulator-clear bits return to zero by themselves after the clear.
// - clear bits 0..7: discharge chg/time, charge chg/time, temp sum/time, cell-two sum/time.
// - five thresholds exist, three voltage and two current.
// - a threshold joins a decision only when its trip enable is set.
// - pack and shelf thresholds meet the pack result, cell threshold meets cell one or two.
// - both current thresholds meet the current result, gated by exit and entry enables.
// - thresholds are left justified like the results.
// - comparisons use magnitude only, sign ignored.
// - results are sign-magnitude with bit 15 the sign.
module gact_regs (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr_lo,
	input wire reg_wr_hi,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire thermistor_pin_in,
	output wire thermistor_pin_out,
	output wire thermistor_pin_oe,
	output wire thermistor_in_buf_en,
	input wire cell_two_pin_in,
	output wire cell_two_pulldown_en,
	output wire cell_two_in_buf_en,
	output reg [7:0] accumulator_clear_pulse,
	input wire [7:0] trip_control,
	input wire [15:0] current_result,
	input wire [15:0] pack_voltage_result,
	input wire [15:0] cell_one_result,
	input wire [15:0] cell_two_result,
	output wire [9:0] trip_flags
);
	reg [5:0] pin_ctrl;
	reg [15:0] positive_current_threshold;
	reg [15:0] negative_current_threshold;
	reg [15:0] pack_voltage_threshold;
	reg [15:0] cell_voltage_threshold;
	reg [15:0] shelf_voltage_threshold;
	reg [1:0] pin0_sync;
	reg [1:0] pin1_sync;
	wire pin0_push_pull_select;
	wire pin0_output_enable;
	wire pin1_input_enable;
	wire pin0_input_enable;
	wire pin1_pulldown_data;
	wire pin0_output_value;
	wire pin0_readback;
	wire pin1_readback;
	wire [7:0] pin_io_control;
	assign pin0_push_pull_select = pin_ctrl[5];
	assign pin0_output_enable = pin_ctrl[4];
	assign pin1_input_enable = pin_ctrl[3];
	assign pin0_input_enable = pin_ctrl[2];
	assign pin1_pulldown_data = pin_ctrl[1];
	assign pin0_output_value = pin_ctrl[0];
	assign thermistor_pin_out = pin0_output_value;
	assign thermistor_pin_oe = pin0_output_enable &&
		(pin0_push_pull_select || !pin0_output_value);
	assign cell_two_pulldown_en = pin1_pulldown_data;
	assign cell_two_in_buf_en = pin1_input_enable;
	assign thermistor_in_buf_en = pin0_input_enable;
	assign pin1_readback = pin1_input_enable && pin1_sync[1];
	assign pin0_readback = pin0_input_enable && pin0_sync[1];
	assign pin_io_control = {pin_ctrl, pin1_readback, pin0_readback};
	always @(posedge mclk) begin
		if (!rst_n) begin
			pin0_sync <= 2'h0;
			pin1_sync <= 2'h0;
		end else begin
			pin0_sync <= {pin0_sync[0], thermistor_pin_in};
			pin1_sync <= {pin1_sync[0], cell_two_pin_in};
		end
	end
	always @(posedge mclk) begin
		if (!rst_n) begin
			pin_ctrl <= `GACT_RESET_PIN_CTRL;
			positive_current_threshold <= `GACT_RESET_THRESHOLD;
			negative_current_threshold <= `GACT_RESET_THRESHOLD;
			pack_voltage_threshold <= `GACT_RESET_THRESHOLD;
			cell_voltage_threshold <= `GACT_RESET_THRESHOLD;
			shelf_voltage_threshold <= `GACT_RESET_THRESHOLD;
		end else begin
			if (reg_wr_lo && reg_addr == `GACT_ADDR_PIN_IO_CONTROL) begin
				pin_ctrl <= reg_wdata[7:2];
			end
			if (reg_addr == `GACT_ADDR_POS_CURRENT) begin
				if (reg_wr_lo) positive_current_threshold[7:0] <= reg_wdata;
				if (reg_wr_hi) positive_current_threshold[15:8] <= reg_wdata;
			end else if (reg_addr == `GACT_ADDR_NEG_CURRENT) begin
				if (reg_wr_lo) negative_current_threshold[7:0] <= reg_wdata;
				if (reg_wr_hi) negative_current_threshold[15:8] <= reg_wdata;
			end else if (reg_addr == `GACT_ADDR_PACK_VOLTAGE) begin
				if (reg_wr_lo) pack_voltage_threshold[7:0] <= reg_wdata;
				if (reg_wr_hi) pack_voltage_threshold[15:8] <= reg_wdata;
			end else if (reg_addr == `GACT_ADDR_CELL_VOLTAGE) begin
				if (reg_wr_lo) cell_voltage_threshold[7:0] <= reg_wdata;
				if (reg_wr_hi) cell_voltage_threshold[15:8] <= reg_wdata;
			end else if (reg_addr == `GACT_ADDR_SHELF_VOLTAGE) begin
				if (reg_wr_lo) shelf_voltage_threshold[7:0] <= reg_wdata;
				if (reg_wr_hi) shelf_voltage_threshold[15:8] <= reg_wdata;
			end
		end
	end
	always @(posedge mclk) begin
		if (!rst_n) begin
			accumulator_clear_pulse <= `GACT_RESET_CLEAR;
		end else if (reg_wr_lo && reg_addr == `GACT_ADDR_ACC_CLEAR) begin
			accumulator_clear_pulse <= reg_wdata;
		end else begin
			accumulator_clear_pulse <= `GACT_RESET_CLEAR;
		end
	end
	always @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `GACT_ADDR_PIN_IO_CONTROL) begin
				reg_rdata <= pin_io_control;
			end else if (reg_addr == `GACT_ADDR_POS_CURRENT) begin
				reg_rdata <= reg_wr_hi ?
					positive_current_threshold[15:8] :
					positive_current_threshold[7:0];
			end else if (reg_addr == `GACT_ADDR_NEG_CURRENT) begin
				reg_rdata <= reg_wr_hi ?
					negative_current_threshold[15:8] :
					negative_current_threshold[7:0];
			end else if (reg_addr == `GACT_ADDR_PACK_VOLTAGE) begin
				reg_rdata <= pack_voltage_threshold[7:0];
			end else if (reg_addr == (`GACT_ADDR_PACK_VOLTAGE + 8'h01)) begin
				reg_rdata <= pack_voltage_threshold[15:8];
			end else if (reg_addr == `GACT_ADDR_CELL_VOLTAGE) begin
				reg_rdata <= cell_voltage_threshold[7:0];
			end else if (reg_addr == (`GACT_ADDR_CELL_VOLTAGE + 8'h01)) begin
				reg_rdata <= cell_voltage_threshold[15:8];
			end else if (reg_addr == `GACT_ADDR_SHELF_VOLTAGE) begin
				reg_rdata <= shelf_voltage_threshold[7:0];
			end else if (reg_addr == (`GACT_ADDR_SHELF_VOLTAGE + 8'h01)) begin
				reg_rdata <= shelf_voltage_threshold[15:8];
			end else if (reg_addr == (`GACT_ADDR_POS_CURRENT + 8'h01)) begin
				reg_rdata <= positive_current_threshold[15:8];
			end else if (reg_addr == (`GACT_ADDR_NEG_CURRENT + 8'h01)) begin
				reg_rdata <= negative_current_threshold[15:8];
			end else begin
				// accumulator_clear reads zero, unmapped reads zero
				reg_rdata <= 8'h00;
			end
		end
	end
	gact_trip_compare #(.WIDTH(16)) cmp_pos (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(positive_current_threshold),
		.result(current_result),
		.enable(trip_control[`GACT_BIT_CURRENT_EXIT]),
		.above(trip_flags[0]),
		.below(trip_flags[1])
	);
	gact_trip_compare #(.WIDTH(16)) cmp_neg (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(negative_current_threshold),
		.result(current_result),
		.enable(trip_control[`GACT_BIT_CURRENT_ENTRY]),
		.above(trip_flags[2]),
		.below(trip_flags[3])
	);
	gact_trip_compare #(.WIDTH(16)) cmp_pack (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(pack_voltage_threshold),
		.result(pack_voltage_result),
		.enable(trip_control[`GACT_BIT_PACK_EXIT]),
		.above(trip_flags[4]),
		.below(trip_flags[5])
	);
	gact_trip_compare #(.WIDTH(16)) cmp_cell1 (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(cell_voltage_threshold),
		.result(cell_one_result),
		.enable(trip_control[`GACT_BIT_CELL_ONE_ENTRY]),
		.above(),
		.below(trip_flags[6])
	);
	gact_trip_compare #(.WIDTH(16)) cmp_cell2 (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(cell_voltage_threshold),
		.result(cell_two_result),
		.enable(trip_control[`GACT_BIT_CELL_TWO_ENTRY]),
		.above(),
		.below(trip_flags[7])
	);
	gact_trip_compare #(.WIDTH(16)) cmp_shelf (
		.mclk(mclk),
		.rst_n(rst_n),
		.threshold(shelf_voltage_threshold),
		.result(pack_voltage_result),
		.enable(trip_control[`GACT_BIT_SHELF_ENTRY]),
		.above(trip_flags[8]),
		.below(trip_flags[9])
	);
endmodule // gact_regs

// ==== gact_regs_chk.sv ====
`timescale 1ns/1ps
module gact_regs_chk (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr_lo,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire thermistor_pin_out,
	input wire thermistor_pin_oe,
	input wire thermistor_in_buf_en,
	input wire cell_two_pulldown_en,
	input wire cell_two_in_buf_en,
	input wire [7:0] accumulator_clear_pulse,
	input wire [7:0] trip_control,
	input wire [9:0] trip_flags
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire gw = reg_wr_lo && reg_addr == 8'h53;
	wire cw = reg_wr_lo && reg_addr == 8'h62;
	a_clear_follows: assert property (cw |=> accumulator_clear_pulse == $past(reg_wdata))
		else $error("clear pulse differs from written byte");
	a_clear_drops: assert property (!cw |=> accumulator_clear_pulse == 8'h00)
		else $error("clear pulse without write");
	a_in1_enable: assert property (gw |=> cell_two_in_buf_en == $past(reg_wdata[5]))
		else $error("cell two buffer enable wrong");
	a_in0_enable: assert property (gw |=> thermistor_in_buf_en == $past(reg_wdata[4]))
		else $error("thermistor buffer enable wrong");
	a_pulldown_set: assert property (gw |=> cell_two_pulldown_en == $past(reg_wdata[3]))
		else $error("pulldown enable wrong");
	a_drive_value: assert property (gw |=> thermistor_pin_out == $past(reg_wdata[2]))
		else $error("thermistor output value wrong");
	a_drive_mode: assert property (gw |=> thermistor_pin_oe ==
		($past(reg_wdata[6]) && ($past(reg_wdata[7]) || !$past(reg_wdata[2]))))
		else $error("thermistor drive mode wrong");
	a_trip_gate: assert property (!trip_control[7] |=> trip_flags[1:0] == 2'b00)
		else $error("current flag while disabled");
	a_in1_zero: assert property (reg_rd && reg_addr == 8'h53 && !cell_two_in_buf_en
		|=> !reg_rdata[1])
		else $error("readback set with buffer off");
endmodule // gact_regs_chk
bind gact_regs gact_regs_chk u_gact_regs_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr_lo(reg_wr_lo), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.thermistor_pin_out(thermistor_pin_out), .thermistor_pin_oe(thermistor_pin_oe),
	.thermistor_in_buf_en(thermistor_in_buf_en), .cell_two_pulldown_en(cell_two_pulldown_en),
	.cell_two_in_buf_en(cell_two_in_buf_en), .accumulator_clear_pulse(accumulator_clear_pulse),
	.trip_control(trip_control), .trip_flags(trip_flags));

// ==== gact_trip_compare.v ====
`timescale 1ns/1ps
`include "gact_map.vh"
module gact_trip_compare #(
	parameter WIDTH = 16
) (
	input wire mclk,
	input wire rst_n,
	input wire [WIDTH-1:0] threshold,
	input wire [WIDTH-1:0] result,
	input wire enable,
	output reg above,
	output reg below
);
	wire [WIDTH-2:0] thr_mag;
	wire [WIDTH-2:0] res_mag;
	assign thr_mag = threshold[WIDTH-2:0];
	assign res_mag = result[WIDTH-2:0];
	always @(posedge mclk) begin
		if (!rst_n) begin
			above <= 1'b0;
			below <= 1'b0;
		end else begin
			above <= enable && (res_mag > thr_mag);
			below <= enable && (res_mag < thr_mag);
		end
	end
endmodule // gact_trip_compare

// ==== gpio_accum_clear_trip_regs_bench.sv ====
`timescale 1ns/1ps
module gpio_accum_clear_trip_regs_bench;
	reg mclk, rst_n, wlo, whi, rd, cdrv;
	reg [7:0] addr, wdata, tc, q;
	reg [15:0] ir, pv, c1, c2;
	wire [7:0] rdata, acp;
	wire [9:0] tf;
	wire tout, toe, tbuf, tin, cin, cpd, cbuf;
	integer fail_count, comparisons, cycles, i;
	gact_regs u_gact_regs (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr_lo(wlo), .reg_wr_hi(whi), .reg_rd(rd), .reg_rdata(rdata),
		.thermistor_pin_in(tin), .thermistor_pin_out(tout), .thermistor_pin_oe(toe),
		.thermistor_in_buf_en(tbuf), .cell_two_pin_in(cin), .cell_two_pulldown_en(cpd),
		.cell_two_in_buf_en(cbuf), .accumulator_clear_pulse(acp), .trip_control(tc),
		.current_result(ir), .pack_voltage_result(pv), .cell_one_result(c1),
		.cell_two_result(c2), .trip_flags(tf));
	gact_pin_model u_gact_pin_model (.therm_out(tout), .therm_oe(toe), .pulldown_en(cpd),
		.cell_drive(cdrv), .therm_wire(tin), .cell_wire(cin));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task chk(input [15:0] s, input [15:0] e);
		begin
			comparisons = comparisons + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("Error at %0t: seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d, input h);
		begin
			@(posedge mclk);
			addr <= a;
			wdata <= d;
			wlo <= !h;
			whi <= h;
			@(posedge mclk);
			wlo <= 1'b0;
			whi <= 1'b0;
			#1;
		end
	endtask
	task rdr(input [7:0] a);
		begin
			@(posedge mclk);
			addr <= a;
			rd <= 1'b1;
			@(posedge mclk);
			rd <= 1'b0;
			#1;
			q = rdata;
		end
	endtask
	task gp(input [7:0] d, input [7:0] e);
		begin
			wr(8'h53, d, 1'b0);
			repeat (4) @(posedge mclk);
			rdr(8'h53);
			chk(q, e);
		end
	endtask
	task t_gpio;
		begin
			gp(8'h03, 8'h00);
			gp(8'h30, 8'h33);
			gp(8'h38, 8'h39);
			chk({cbuf, tbuf, cpd}, 3'b111);
			gp(8'h74, 8'h77);
			chk(toe, 1'b0);
			gp(8'hf0, 8'hf2);
			chk(toe, 1'b1);
			gp(8'hd4, 8'hd5);
			chk({toe, tout}, 2'b11);
			chk({cbuf, tbuf, cpd}, 3'b010);
		end
	endtask
	task t_clear;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				wr(8'h62, 8'h01 << i, 1'b0);
				chk(acp, 8'h01 << i);
				@(posedge mclk);
				#1;
				chk(acp, 8'h00);
			end
			rdr(8'h62);
			chk(q, 8'h00);
		end
	endtask
	task trip(input [15:0] cur, input [7:0] en);
		begin
			@(posedge mclk);
			ir <= cur;
			tc <= en;
			repeat (2) @(posedge mclk);
			#1;
		end
	endtask
	task t_thresh;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				wr(8'h60 + 8'h04 * i[7:0], 8'h3c ^ i[7:0], 1'b0);
				wr(8'h60 + 8'h04 * i[7:0], 8'hc0 | i[7:0], 1'b1);
				rdr(8'h60 + 8'h04 * i[7:0]);
				chk(q, 8'h3c ^ i[7:0]);
				rdr(8'h61 + 8'h04 * i[7:0]);
				chk(q, 8'hc0 | i[7:0]);
			end
			wr(8'h60, 8'h00, 1'b0);
			wr(8'h60, 8'h81, 1'b1);
			trip(16'h0200, 8'h80);
			chk(tf[1:0], 2'b01);
			trip(16'h8080, 8'h80);
			chk(tf[1:0], 2'b10);
			trip(16'h8080, 8'h00);
			chk(tf[1:0], 2'b00);
			wr(8'h6c, 8'h00, 1'b0);
			wr(8'h6c, 8'h40, 1'b1);
			trip(16'h0000, 8'h18);
			chk(tf[7:6], 2'b10);
			trip(16'hffff, 8'h40);
			chk(tf, 10'h004);
			@(posedge mclk);
			pv <= 16'hc300;
			trip(16'h0000, 8'h24);
			chk(tf, 10'h210);
		end
	endtask
	task conclude;
		begin
			$display("mismatches %0d comparisons %0d", fail_count, comparisons);
			if (fail_count == 0 && comparisons > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cycles = cycles + 1;
		if (cycles == 5000) begin
			fail_count = fail_count + 1;
			conclude;
		end
	end
	initial begin
		{fail_count, comparisons, cycles} = 0;
		{rst_n, wlo, whi, rd, addr, wdata, tc, ir, pv} = 0;
		cdrv = 1'b1;
		c1 = 16'hc000;
		c2 = 16'h2000;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_gpio;
		t_clear;
		t_thresh;
		conclude;
	end
endmodule // gpio_accum_clear_trip_regs_bench
